// [logic/cfg_capture.sv]
// Samples the program-once fuse lines and latches them once after reset.
// Assumes the fuse lines are static but asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module cfg_capture (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [dog_pkg::CFG_W-1:0] fuse_word, // Raw fuse lines
  output logic [dog_pkg::CFG_W-1:0] cfg_word, // Latched word
  output logic cfg_loaded, // Word is valid
  output logic load_pulse // One cycle at load
);
  import dog_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] s1;
    logic [CFG_W-1:0] s2;
    logic [CFG_W-1:0] word;
    logic [2:0] cnt;
    logic loaded;
    logic pulse;
  } cap_s;

  cap_s st_reg;
  cap_s st_next;

  // ----------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------
  // Wait for the synchroniser to fill, then freeze: the word cannot change
  // until the next reset, whatever the fuse lines do.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = fuse_word;
    st_next.s2 = st_reg.s1;
    st_next.pulse = 1'b0;
    if (!st_reg.loaded) begin
      if (st_reg.cnt == CAP_SETTLE) begin
        st_next.word = st_reg.s2;
        st_next.loaded = 1'b1;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end

  // Erased word until loaded keeps the safest settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{s1: CFG_ERASED, s2: CFG_ERASED, word: CFG_ERASED,
                  cnt: 3'h0, loaded: 1'b0, pulse: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_word = st_reg.word;
  assign cfg_loaded = st_reg.loaded;
  assign load_pulse = st_reg.pulse;
endmodule
`default_nettype wire

// [logic/dog_decode.sv]
// Combinational decode of the configuration word into watchdog settings.
// Assumes the word is stable and that its inputs share aclk.
`timescale 1ns/1ps
`default_nettype none
module dog_decode (
  input wire logic [dog_pkg::CFG_W-1:0] cfg_word, // Latched word
  input wire logic sw_on, // Software on bit
  input wire logic in_sleep, // Device asleep
  input wire logic sysclk_int, // System clock is internal or slow RC
  output logic run, // Watchdog runs
  output logic [dog_pkg::PER_W-1:0] period_exp, // Divide by 2^exp
  output logic [2:0] window_eighths, // Window in eighths
  output logic window_mode, // Window mode on
  output dog_pkg::dog_src_e clk_src // Selected clock
);
  import dog_pkg::*;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  always_comb begin
    run = cfg_word[HW_EN_BIT] | sw_on;
    period_exp = in_sleep ? cfg_word[SLP_LSB +: PER_W] : cfg_word[RUN_LSB +: PER_W];
    window_mode = ~cfg_word[WINDOW_DISABLE_BIT];
    case (cfg_word[WIN_LSB +: 2])
      WSEL_25: window_eighths = EIGHTHS_25;
      WSEL_37: window_eighths = EIGHTHS_37;
      WSEL_50: window_eighths = EIGHTHS_50;
      default: window_eighths = EIGHTHS_75;
    endcase
    // Reserved select falls back to slow RC so the dog never loses its clock
    case (cfg_word[CLK_LSB +: 2])
      CSEL_SLOW_RC: clk_src = SRC_SLOW_RC;
      CSEL_FAST_RC: begin
        clk_src = (window_mode && !sysclk_int && !in_sleep) ?
          SRC_FAST_RC : SRC_SLOW_RC;
      end
      CSEL_PB: begin
        clk_src = (!sysclk_int && !in_sleep) ? SRC_PBCLK : SRC_SLOW_RC;
      end
      default: clk_src = SRC_SLOW_RC;
    endcase
  end
endmodule
`default_nettype wire

// [logic/dog_pkg.sv]
// Constants shared by the watchdog configuration decoder files.
// Assumes a 24-bit program-once word and a 32-bit AXI4-Lite slave.
package dog_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 24;
  localparam logic [23:0] CFG_ERASED = 24'hffffff;
  localparam logic [23:0] CFG_UNIMPL = 24'hff0000;
  localparam int HW_EN_BIT = 15;
  localparam int SLP_LSB = 10;
  localparam int WIN_LSB = 8;
  localparam int WINDOW_DISABLE_BIT = 7;
  localparam int CLK_LSB = 5;
  localparam int RUN_LSB = 0;
  localparam int PER_W = 5;
  localparam logic [1:0] CSEL_SLOW_RC = 2'h3;
  localparam logic [1:0] CSEL_FAST_RC = 2'h2;
  localparam logic [1:0] CSEL_PB = 2'h1;
  localparam logic [1:0] WSEL_25 = 2'h3;
  localparam logic [1:0] WSEL_37 = 2'h2;
  localparam logic [1:0] WSEL_50 = 2'h1;
  localparam logic [2:0] EIGHTHS_25 = 3'h2;
  localparam logic [2:0] EIGHTHS_37 = 3'h3;
  localparam logic [2:0] EIGHTHS_50 = 3'h4;
  localparam logic [2:0] EIGHTHS_75 = 3'h6;
  localparam logic [2:0] CAP_SETTLE = 3'h3;

  // ----------------------------------------------------------------
  // Control, status and interrupt layout
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 15;
  localparam int ST_RUN = 0;
  localparam int ST_WINMODE = 1;
  localparam int ST_SRC_LSB = 2;
  localparam int ST_SLEEP = 4;
  localparam int ST_EXP_LSB = 5;
  localparam int ST_WIN_LSB = 10;
  localparam int ST_LOADED = 13;
  localparam int IRQ_W = 3;
  localparam int IRQ_LOAD = 0;
  localparam int IRQ_PWR = 1;
  localparam int IRQ_SRC = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_SLOW_RC = 2'b00,
    SRC_FAST_RC = 2'b01,
    SRC_PBCLK = 2'b10
  } dog_src_e;

endpackage

// [logic/watchdog_config_decode.sv]
// Watchdog configuration decoder with AXI4-Lite register access.
// Assumes sleep and clock-status inputs come from logic on aclk and the
// fuse lines are asynchronous static levels.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module watchdog_config_decode (
  input wire logic aclk, // 20 MHz system clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [dog_pkg::CFG_W-1:0] fuse_word, // Program-once fuse lines
  input wire logic in_sleep, // Device in sleep
  input wire logic sysclk_int, // System clock is internal or slow RC
  // AXI4-Lite write address
  input wire logic [dog_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  // AXI4-Lite read
  input wire logic [dog_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  // Decoded watchdog settings
  output logic dog_run, // Watchdog runs
  output logic [dog_pkg::PER_W-1:0] dog_period_exp, // Active divider exponent
  output logic [2:0] dog_window_eighths, // Window size in eighths
  output logic dog_window_mode, // Window mode active
  output dog_pkg::dog_src_e dog_clk_src, // Watchdog clock source
  output logic irq // Level interrupt
);
  import dog_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Register map, byte addresses on the slave:
  //   0x00 configuration word, read only; a write answers SLVERR
  //   0x04 control, bit 15 is the software on bit
  //   0x08 status, read-only view of what the outputs drive
  //   0x0c interrupt status, write one to clear
  //   0x10 interrupt mask, same layout as the status bits
  //   anything else reads zero and answers SLVERR either way
  // Interrupt bits: 0 word loaded, 1 power state changed, 2 clock source
  // changed. The source event waits until the word has loaded, so the
  // step from reset defaults to the fuse settings never raises it.
  // Status bits: 0 run, 1 window mode, 3..2 source, 4 asleep,
  // 9..5 active exponent, 12..10 window eighths, 13 word loaded.
  // All state lives in one packed struct: a single register process
  // holds it and every output leaves straight from a flop.
  // Trade-off: the decoded outputs lag their inputs by one cycle.

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_on;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic run;
    logic [PER_W-1:0] exp;
    logic [2:0] win;
    logic winmode;
    dog_src_e src;
    logic sleep_prev;
    logic loaded;
  } top_s;

  top_s st_reg;
  top_s st_next;

  // Wires between the submodules and the register process
  logic [CFG_W-1:0] cfg_word;
  logic cfg_loaded;
  logic load_pulse;
  logic dec_run;
  logic [PER_W-1:0] dec_exp;
  logic [2:0] dec_win;
  logic dec_winmode;
  dog_src_e dec_src;
  logic [31:0] status_word;
  logic [31:0] cfg_read;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Fuse lines are synchronised and frozen once per reset
  cfg_capture u_cap (
    .aclk(aclk),
    .aresetn(aresetn),
    .fuse_word(fuse_word),
    .cfg_word(cfg_word),
    .cfg_loaded(cfg_loaded),
    .load_pulse(load_pulse)
  );

  // Pure decode; its results are registered here before leaving
  dog_decode u_dec (
    .cfg_word(cfg_word),
    .sw_on(st_reg.ctrl_on),
    .in_sleep(in_sleep),
    .sysclk_int(sysclk_int),
    .run(dec_run),
    .period_exp(dec_exp),
    .window_eighths(dec_win),
    .window_mode(dec_winmode),
    .clk_src(dec_src)
  );

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Unimplemented upper bits read as ones, bits above the word as zero
  assign cfg_read = {8'h00, cfg_word | CFG_UNIMPL};

  // Status shows what the outputs currently drive
  always_comb begin
    status_word = 32'h0;
    status_word[ST_RUN] = st_reg.run;
    status_word[ST_WINMODE] = st_reg.winmode;
    status_word[ST_SRC_LSB +: 2] = st_reg.src;
    status_word[ST_SLEEP] = st_reg.sleep_prev;
    status_word[ST_EXP_LSB +: PER_W] = st_reg.exp;
    status_word[ST_WIN_LSB +: 3] = st_reg.win;
    status_word[ST_LOADED] = st_reg.loaded;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Slave timing: a half taken at edge N is held, the write happens at
  // the next edge and bvalid rises with it. A read is answered at the edge
  // that takes its address. A ready drops while its own half or response is open, so
  // at most one write and one read are under way.
  // Hazard avoided: no write path reaches the latched word at all.
  always_comb begin
    logic do_write;
    logic [IRQ_W-1:0] ev_set;
    logic [IRQ_W-1:0] ev_clr;
    do_write = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    st_next = st_reg;

    // Address and data are taken in either order and held
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end

    // Response retires the pending write
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      do_write = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.awaddr)
        OFS_CTRL: begin
          if (st_reg.wstrb[1]) begin
            st_next.ctrl_on = st_reg.wdata[CTRL_ON_BIT];
          end
        end
        OFS_IRQ_STAT: begin
          if (st_reg.wstrb[0]) begin
            ev_clr = st_reg.wdata[IRQ_W-1:0];
          end
        end
        OFS_IRQ_MASK: begin
          if (st_reg.wstrb[0]) begin
            st_next.irq_mask = st_reg.wdata[IRQ_W-1:0];
          end
        end
        // Program-once word refuses software writes
        OFS_CFG: st_next.bresp = RESP_SLVERR;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end

    // One read at a time, answered the cycle after it is taken
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CFG: st_next.rdata = cfg_read;
        OFS_CTRL: st_next.rdata = {16'h0, st_reg.ctrl_on, 15'h0};
        OFS_STAT: st_next.rdata = status_word;
        OFS_IRQ_STAT: st_next.rdata = {29'h0, st_reg.irq_stat};
        OFS_IRQ_MASK: st_next.rdata = {29'h0, st_reg.irq_mask};
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Ready flags: one write and one read in flight at most
    st_next.awready = !st_next.aw_got && !st_next.bvalid && !do_write;
    st_next.wready = !st_next.w_got && !st_next.bvalid && !do_write;
    st_next.arready = !st_next.rvalid;

    // Register decoded settings so outputs leave from flops
    st_next.run = dec_run;
    st_next.exp = dec_exp;
    st_next.win = dec_win;
    st_next.winmode = dec_winmode;
    st_next.src = dec_src;
    st_next.sleep_prev = in_sleep;
    st_next.loaded = cfg_loaded;

    // Events: load, power-state change, clock source change
    // Each is a one-cycle strobe into the sticky bits below
    ev_set[IRQ_LOAD] = load_pulse;
    ev_set[IRQ_PWR] = (in_sleep != st_reg.sleep_prev);
    ev_set[IRQ_SRC] = st_reg.loaded && (dec_src != st_reg.src);

    // A set in the same cycle as its clear wins, so no event is lost
    st_next.irq_stat = (st_reg.irq_stat & ~ev_clr) | ev_set;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Software on bit resets off, so only the fuse can start the dog early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{aw_got: 1'b0, w_got: 1'b0, awaddr: '0, wdata: '0,
                  wstrb: '0, awready: 1'b0, wready: 1'b0, bvalid: 1'b0,
                  bresp: RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
                  rdata: '0, rresp: RESP_OKAY, ctrl_on: 1'b0,
                  irq_stat: '0, irq_mask: '0, irq: 1'b0, run: 1'b0,
                  exp: '0, win: '0, winmode: 1'b0, src: SRC_SLOW_RC,
                  sleep_prev: 1'b0, loaded: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus handshake outputs, each a plain copy of a state bit
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  // Decoded settings and the interrupt line
  assign dog_run = st_reg.run;
  assign dog_period_exp = st_reg.exp;
  assign dog_window_eighths = st_reg.win;
  assign dog_window_mode = st_reg.winmode;
  assign dog_clk_src = st_reg.src;
  assign irq = st_reg.irq;
endmodule
`default_nettype wire

// [sim/dog_props.sv]
// Assertions on the decoded watchdog outputs and config-word access.
// Assumes fuse lines change only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module dog_props (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic [23:0] fuse_word, // Fuse lines
  input wire logic in_sleep, // Asleep
  input wire logic sysclk_int, // Internal system clock
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic dog_run, // Runs
  input wire logic [4:0] dog_period_exp, // Divider exponent
  input wire logic [2:0] dog_window_eighths, // Window size
  input wire logic dog_window_mode, // Window mode
  input wire dog_pkg::dog_src_e dog_clk_src // Clock source
);
  import dog_pkg::*;
  // ----------------------------------------------------------------
  // Helpers and checks
  // ----------------------------------------------------------------
  logic [3:0] age_reg; // Cycles since reset, saturating
  logic [7:0] ar_q_reg; // Last read address
  logic [7:0] aw_q_reg; // Last write address
  wire settled = age_reg > 4'h9;
  // Wait out sync and load so the decode checks never see reset zeros
  always_ff @(posedge aclk) begin
    if (!aresetn) age_reg <= 4'h0;
    else if (!settled) age_reg <= age_reg + 4'h1;
    if (s_axi_arvalid && s_axi_arready) ar_q_reg <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) aw_q_reg <= s_axi_awaddr;
  end
  function automatic logic [2:0] win8(logic [1:0] w);
    return (w == 2'h3) ? 3'h2 : (w == 2'h2) ? 3'h3 : (w == 2'h1) ? 3'h4 : 3'h6;
  endfunction
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence cfg_read_ret;
    settled && s_axi_rvalid && ar_q_reg == OFS_CFG;
  endsequence
  sequence cfg_write_ret;
    s_axi_bvalid && aw_q_reg == OFS_CFG;
  endsequence
  chk_hw_force_run: assert property (settled && fuse_word[15] |-> dog_run)
    else $error("forced watchdog not running");
  chk_sleep_period: assert property (settled && $past(in_sleep) |->
    dog_period_exp == fuse_word[14:10]) else $error("sleep divider wrong");
  chk_run_period: assert property (settled && !$past(in_sleep) |->
    dog_period_exp == fuse_word[4:0]) else $error("run divider wrong");
  chk_window_size: assert property (settled |->
    dog_window_eighths == win8(fuse_word[9:8])) else $error("window size wrong");
  chk_window_mode: assert property (settled |->
    dog_window_mode == !fuse_word[7]) else $error("window mode wrong");
  chk_src_lowpower: assert property (settled && fuse_word[6:5] == 2'h3 |->
    dog_clk_src == SRC_SLOW_RC) else $error("select 11 not low-power clock");
  chk_src_fast: assert property (settled && fuse_word[6:5] == 2'h2 |->
    dog_clk_src == ((!fuse_word[7] && !$past(sysclk_int) && !$past(in_sleep)) ?
    SRC_FAST_RC : SRC_SLOW_RC)) else $error("select 10 source wrong");
  chk_src_periph: assert property (settled && fuse_word[6:5] == 2'h1 |->
    dog_clk_src == ((!$past(sysclk_int) && !$past(in_sleep)) ? SRC_PBCLK : SRC_SLOW_RC))
    else $error("select 01 source wrong");
  chk_unimpl_ones: assert property (cfg_read_ret |-> s_axi_rdata[23:16] == 8'hff)
    else $error("unimplemented bits not one");
  chk_cfg_readback: assert property (cfg_read_ret |->
    s_axi_rdata[15:0] == fuse_word[15:0]) else $error("config readback wrong");
  chk_cfg_locked: assert property (cfg_write_ret |-> s_axi_bresp == RESP_SLVERR)
    else $error("config write accepted");
endmodule
bind watchdog_config_decode dog_props chk (.aclk, .aresetn, .fuse_word, .in_sleep,
  .sysclk_int, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .dog_run, .dog_period_exp, .dog_window_eighths, .dog_window_mode,
  .dog_clk_src);
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the watchdog configuration decoder.
// Assumes the AXI4-Lite slave and decode lag described by the designer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("FAIL t=%0t %s", $time, msg); end end
module tb;
  import dog_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, tasks and tests
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [23:0] fuse_word = 24'hffffff;
  logic in_sleep = 1'b0, sysclk_int = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dog_run, dog_window_mode, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] dog_period_exp;
  logic [2:0] dog_window_eighths;
  dog_src_e dog_clk_src;
  logic [31:0] rd;
  logic [23:0] f;
  logic [23:0] cfgs [9];
  int miscompares = 0;
  int total_checks = 0;
  // 20 MHz clock
  always #25 aclk = ~aclk;
  watchdog_config_decode dut (.aclk, .aresetn, .fuse_word, .in_sleep, .sysclk_int,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dog_run, .dog_period_exp, .dog_window_eighths,
    .dog_window_mode, .dog_clk_src, .irq);
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // New fuse value only under reset, as real fuses never move at run time
  task automatic boot(input logic [23:0] v);
    aresetn <= 1'b0;
    fuse_word <= v;
    in_sleep <= 1'b0;
    sysclk_int <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask
  function automatic dog_src_e exp_src(logic [23:0] v, logic s, logic i);
    if (v[6:5] == 2'h2 && !v[7] && !s && !i) return SRC_FAST_RC;
    if (v[6:5] == 2'h1 && !s && !i) return SRC_PBCLK;
    return SRC_SLOW_RC;
  endfunction
  function automatic logic [2:0] exp_win(logic [1:0] w);
    return (w == 2'h3) ? 3'h2 : (w == 2'h2) ? 3'h3 : (w == 2'h1) ? 3'h4 : 3'h6;
  endfunction
  // Load event, masking, clear and unmapped places
  task automatic irq_test();
    rd_reg(OFS_IRQ_STAT);
    `CHK(rd[2:0], 3'h1, "load event")
    `CHK(irq, 1'b0, "masked load")
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1, "unmasked load")
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0, "cleared")
    in_sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0, "sleep event masked")
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1, "sleep event")
    rd_reg(8'h40);
    `CHK({resp, rd}, {RESP_SLVERR, 32'h0}, "unmapped read")
    wr(8'h40, 32'h0);
    `CHK(resp, RESP_SLVERR, "unmapped write")
  endtask
  initial begin
    void'($urandom(46388));
    // 007ec0: select 10 with window mode off, and the 37.5 percent window
    cfgs = '{24'hffffff, 24'h000000, 24'h007c40, 24'h00a31f, 24'h0001a5, 24'h007ec0,
      0, 0, 0};
    for (int i = 6; i < 9; i++) cfgs[i] = 24'($urandom());
    for (int t = 0; t < 9; t++) begin
      boot(cfgs[t]);
      f = cfgs[t];
      rd_reg(OFS_CFG);
      `CHK(rd, {8'h00, 8'hff, f[15:0]}, "config readback")
      wr(OFS_CFG, $urandom());
      `CHK(resp, RESP_SLVERR, "config write refused")
      rd_reg(OFS_CFG);
      `CHK(rd, {8'h00, 8'hff, f[15:0]}, "config unchanged")
      if (t == 0) irq_test();
      // Every sleep and system clock pairing, software bit off then on
      for (int k = 0; k < 8; k++) begin
        if (k % 4 == 0) wr(OFS_CTRL, {16'h0, k[2], 15'h0});
        in_sleep <= k[0];
        sysclk_int <= k[1];
        repeat (3) @(posedge aclk);
        `CHK(dog_run, f[15] | k[2], "run state")
        `CHK(dog_period_exp, k[0] ? f[14:10] : f[4:0], "period")
        `CHK(dog_window_eighths, exp_win(f[9:8]), "window size")
        `CHK(dog_window_mode, ~f[7], "window mode")
        `CHK(dog_clk_src, exp_src(f, k[0], k[1]), "clock source")
      end
      $display("Test %0d done, config %h", t, f);
    end
    tally_and_finish();
  end
  // Hang guard at 20000 cycles, far beyond the fewer than a thousand cycles the tests take
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
